// file: src/trig_ctl.sv
// Input trigger measurement controller with an AHB-Lite register slave.
//
// The AHB-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module trig_ctl (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Hardware trigger pin.
    input wire logic trig_in,
    // Measurement engine.
    output logic meas_start,
    input wire logic meas_done
);
    //--------------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------------
    logic [6:0] ctrl_reg;
    logic [15:0] len_reg;
    logic [15:0] left_reg;
    logic [15:0] taken_reg;
    logic [15:0] dropped_reg;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic [31:0] hrdata_reg;
    logic [2:0] trig_sync_reg;
    logic armed_reg;
    logic busy_reg;
    logic oneshot_reg;
    logic func_done_reg;
    logic meas_start_reg;
    trig_ctl_pkg::state_type state_reg;
    trig_ctl_pkg::state_type state_next;
    trig_ctl_pkg::resp_type resp;
    trig_ctl_pkg::func_type func;
    logic rearm_en;
    logic cont;
    logic addr_ok;
    logic cmd_wr;
    logic do_start;
    logic do_rearm;
    logic do_func;
    logic do_stop;
    logic pulse;
    logic free;
    logic gate;
    logic accept;
    logic auto_req;
    logic issue;
    logic last_done;
    //--------------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------------
    // True when a remembered write address selects the given register word.
    function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] offset);
        return addr == offset;
    endfunction : word_hit
    // True when the response mode throws hardware pulses away.
    function automatic logic discards(input trig_ctl_pkg::resp_type mode);
        return mode == trig_ctl_pkg::discard_pulses;
    endfunction : discards
    //--------------------------------------------------------------------------
    // Register bus
    //--------------------------------------------------------------------------
    // A request is taken in its address phase when the bus is ready.
    assign addr_ok = hsel && htrans[1] && hready;
    // Writes are remembered for their data phase.
    always_ff @(posedge clock) begin
        if (srst) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite;
            wr_addr_reg <= haddr[7:0];
        end
    end
    // The slave never inserts wait states and always answers OKAY.
    // Ready is low while reset is held and until the first edge after release, so a master waits one edge after release.
    always_ff @(posedge clock) begin
        if (srst) begin
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
    // Read data is captured at the address phase; unmapped words read zero.
    always_ff @(posedge clock) begin
        if (srst) begin
            hrdata_reg <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            case (haddr[7:0])
                trig_ctl_pkg::ctrl_offset: hrdata_reg <= {25'h0000000, ctrl_reg};
                trig_ctl_pkg::len_offset: hrdata_reg <= {16'h0000, len_reg};
                trig_ctl_pkg::status_offset: hrdata_reg <= {left_reg, 8'h00, func_done_reg,
                    oneshot_reg, busy_reg, armed_reg, 1'b0, state_reg};
                trig_ctl_pkg::count_offset: hrdata_reg <= {dropped_reg, taken_reg};
                default: hrdata_reg <= 32'h00000000;
            endcase
        end
    end
    assign hrdata = hrdata_reg;
    // Control and length registers take their data phase word.
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_reg <= trig_ctl_pkg::ctrl_reset;
            len_reg <= trig_ctl_pkg::len_reset;
        end else if (wr_pend_reg) begin
            if (word_hit(wr_addr_reg, trig_ctl_pkg::ctrl_offset)) begin
                ctrl_reg <= hwdata[6:0];
            end
            if (word_hit(wr_addr_reg, trig_ctl_pkg::len_offset)) begin
                len_reg <= hwdata[15:0];
            end
        end
    end
    // Command strobes last the data phase cycle only.
    assign cmd_wr = wr_pend_reg && word_hit(wr_addr_reg, trig_ctl_pkg::cmd_offset);
    assign do_start = cmd_wr && hwdata[trig_ctl_pkg::cmd_start_bit];
    assign do_rearm = cmd_wr && hwdata[trig_ctl_pkg::cmd_rearm_bit];
    assign do_func = cmd_wr && hwdata[trig_ctl_pkg::cmd_func_bit];
    assign do_stop = cmd_wr && hwdata[trig_ctl_pkg::cmd_stop_bit];
    // Decoded settings.
    assign resp = trig_ctl_pkg::resp_type'(ctrl_reg[trig_ctl_pkg::resp_lsb +: 2]);
    assign func = trig_ctl_pkg::func_type'(ctrl_reg[trig_ctl_pkg::func_lsb +: 2]);
    assign rearm_en = ctrl_reg[trig_ctl_pkg::rearm_en_bit];
    assign cont = ctrl_reg[trig_ctl_pkg::cont_bit];
    //--------------------------------------------------------------------------
    // Trigger input
    //--------------------------------------------------------------------------
    // Two flip-flops resynchronise the pin, the third gives the rising edge.
    always_ff @(posedge clock) begin
        if (srst) begin
            trig_sync_reg <= 3'b000;
        end else begin
            trig_sync_reg <= {trig_sync_reg[1:0], trig_in};
        end
    end
    // The edge is taken after the second stage, so a metastable first stage is never read.
    assign pulse = trig_sync_reg[1] && !trig_sync_reg[2];
    // No new measurement may start while one is pending or running.
    // A pulse that arrives while the engine is busy is counted as refused, not queued.
    assign free = !busy_reg && !meas_start_reg;
    // Pulse gating per state; record functions bypass the armed flag.
    always_comb begin
        case (state_reg)
            trig_ctl_pkg::st_listen: gate = !discards(resp) && armed_reg;
            trig_ctl_pkg::st_func_pulse,
            trig_ctl_pkg::st_func_wait: gate = (func != trig_ctl_pkg::extremes_tracking_function)
                || rearm_en || armed_reg;
            default: gate = 1'b0;
        endcase
    end
    assign accept = pulse && free && gate;
    // Armed flag; a rearm in the same cycle as a consumed pulse wins.
    always_ff @(posedge clock) begin
        if (srst) begin
            armed_reg <= 1'b1;
        end else if (do_rearm) begin
            armed_reg <= 1'b1;
        end else if (accept && !rearm_en) begin
            armed_reg <= 1'b0;
        end
    end
    // Accepted and refused pulse counters.
    always_ff @(posedge clock) begin
        if (srst) begin
            taken_reg <= 16'h0000;
            dropped_reg <= 16'h0000;
        end else if (pulse) begin
            if (accept) begin
                taken_reg <= taken_reg + 16'h0001;
            end else begin
                dropped_reg <= dropped_reg + 16'h0001;
            end
        end
    end
    //--------------------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------------------
    // The last measurement of a function finishes it.
    assign last_done = meas_done && busy_reg && (left_reg == 16'h0001);
    // State transitions.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            trig_ctl_pkg::st_idle: begin
                if (cont && discards(resp)) begin
                    state_next = trig_ctl_pkg::st_auto;
                end else if (cont || (do_start && !discards(resp))) begin
                    state_next = trig_ctl_pkg::st_listen;
                end
            end
            trig_ctl_pkg::st_listen,
            trig_ctl_pkg::st_auto: begin
                if (!cont && !do_start && state_reg == trig_ctl_pkg::st_auto) begin
                    state_next = trig_ctl_pkg::st_idle;
                end
            end
            trig_ctl_pkg::st_func_wait: begin
                if (accept) begin
                    state_next = trig_ctl_pkg::st_func_auto;
                end
            end
            trig_ctl_pkg::st_func_pulse,
            trig_ctl_pkg::st_func_auto: begin
                if (last_done) begin
                    state_next = trig_ctl_pkg::st_idle;
                end
            end
            default: state_next = trig_ctl_pkg::st_idle;
        endcase
        if (do_func && len_reg != 16'h0000) begin
            case (resp)
                trig_ctl_pkg::single_measure_per_pulse: state_next = trig_ctl_pkg::st_func_pulse;
                trig_ctl_pkg::pulse_launches_function: state_next = trig_ctl_pkg::st_func_wait;
                default: state_next = trig_ctl_pkg::st_func_auto;
            endcase
        end
        // A stop command wins over a function start written in the same word.
        if (do_stop) begin
            state_next = trig_ctl_pkg::st_idle;
        end
    end
    // State register.
    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= trig_ctl_pkg::st_idle;
        end else begin
            state_reg <= state_next;
        end
    end
    // Measurements left in the running function.
    // The counter never wraps below zero, so a stray done pulse after a stop is harmless.
    always_ff @(posedge clock) begin
        if (srst) begin
            left_reg <= 16'h0000;
        end else if (do_func) begin
            left_reg <= len_reg;
        end else if (meas_done && busy_reg && left_reg != 16'h0000) begin
            left_reg <= left_reg - 16'h0001;
        end
    end
    // Sticky completion flag, cleared by the next function start.
    always_ff @(posedge clock) begin
        if (srst) begin
            func_done_reg <= 1'b0;
        end else if (last_done && state_reg != trig_ctl_pkg::st_idle) begin
            func_done_reg <= 1'b1;
        end else if (do_func) begin
            func_done_reg <= 1'b0;
        end
    end
    // One software measurement for an immediate start in discard response.
    always_ff @(posedge clock) begin
        if (srst) begin
            oneshot_reg <= 1'b0;
        end else if (do_stop) begin
            oneshot_reg <= 1'b0;
        end else if (do_start && discards(resp)) begin
            oneshot_reg <= 1'b1;
        end else if (issue) begin
            oneshot_reg <= 1'b0;
        end
    end
    // Self-paced measurement requests.
    assign auto_req = (state_reg == trig_ctl_pkg::st_auto) || (state_reg == trig_ctl_pkg::st_func_auto);
    // A pulse and a self-paced request in one cycle still give a single start strobe.
    assign issue = accept || (free && (auto_req || oneshot_reg));
    // Start strobe to the measurement engine.
    // A stop in the same cycle suppresses a start that was about to go out.
    always_ff @(posedge clock) begin
        if (srst) begin
            meas_start_reg <= 1'b0;
        end else begin
            meas_start_reg <= issue && !do_stop;
        end
    end
    assign meas_start = meas_start_reg;
    // A measurement is in flight from its start strobe to its done pulse.
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_reg <= 1'b0;
        end else if (meas_start_reg) begin
            busy_reg <= 1'b1;
        end else if (meas_done) begin
            busy_reg <= 1'b0;
        end
    end
endmodule : trig_ctl
`default_nettype wire

// file: src/trig_ctl_pkg.sv
// Constants, types and register map of the input trigger measurement controller.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`default_nettype none
package trig_ctl_pkg;
    // Register byte offsets.
    localparam logic [7:0] ctrl_offset = 8'h00;
    localparam logic [7:0] cmd_offset = 8'h04;
    localparam logic [7:0] len_offset = 8'h08;
    localparam logic [7:0] status_offset = 8'h0c;
    localparam logic [7:0] count_offset = 8'h10;
    // Control field positions.
    localparam int resp_lsb = 0;
    localparam int rearm_en_bit = 2;
    localparam int func_lsb = 4;
    localparam int cont_bit = 6;
    // Command bits.
    localparam int cmd_start_bit = 0;
    localparam int cmd_rearm_bit = 1;
    localparam int cmd_func_bit = 2;
    localparam int cmd_stop_bit = 3;
    // Reset values.
    localparam logic [6:0] ctrl_reset = 7'h00;
    localparam logic [15:0] len_reset = 16'h0001;
    // Trigger response modes.
    typedef enum logic [1:0] {
        discard_pulses = 2'b00,
        single_measure_per_pulse = 2'b01,
        pulse_launches_function = 2'b10
    } resp_type;
    // Acquisition functions.
    typedef enum logic [1:0] {
        no_function = 2'b00,
        extremes_tracking_function = 2'b01,
        sample_record_function = 2'b10,
        drift_record_function = 2'b11
    } func_type;
    // Controller states.
    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_listen = 3'b001,
        st_auto = 3'b010,
        st_func_pulse = 3'b011,
        st_func_wait = 3'b100,
        st_func_auto = 3'b101
    } state_type;
endpackage : trig_ctl_pkg
`default_nettype wire

// file: tb/trig_ctl_asserts.sv
// Port assertions of the trigger controller.
`timescale 1ns/1ns
`default_nettype none
module trig_ctl_asserts (
    // Clock and reset.
    input wire logic clock,
    input wire logic srst,
    // Bus and engine.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic meas_start,
    input wire logic meas_done
);
    logic busy_reg;
    logic cfg_reg;
    logic take;
    // A bus transfer is taken on this cycle.
    assign take = hsel && htrans[1] && hready;
    // Tracks an open measurement and whether anything was written since reset.
    always_ff @(posedge clock) begin
        if (srst) begin
            busy_reg <= 1'b0;
            cfg_reg <= 1'b0;
        end else begin
            if (meas_start) busy_reg <= 1'b1;
            else if (meas_done) busy_reg <= 1'b0;
            if (take && hwrite) cfg_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    a_start_one_cycle: assert property (meas_start |=> !meas_start)
        else $error("meas_start held beyond one cycle");
    a_one_at_once: assert property (meas_start |-> !busy_reg)
        else $error("meas_start before the previous measurement ended");
    a_discard_at_reset: assert property (!cfg_reg |-> !meas_start)
        else $error("measurement started in the reset response mode");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("hresp not okay");
    a_ready_release: assert property ($fell(srst) |-> !hreadyout ##1 hreadyout)
        else $error("hreadyout wrong around reset release");
    a_ready_steady: assert property (!$past(srst) |-> hreadyout)
        else $error("hreadyout low outside reset");
    a_reset_quiet: assert property ($fell(srst) |-> !meas_start && hrdata == 32'h0)
        else $error("outputs not cleared by reset");
    a_cmd_reads_zero: assert property (take && !hwrite && haddr == {24'h000000, trig_ctl_pkg::cmd_offset}
        |=> hrdata == 32'h0)
        else $error("command register read not zero");
endmodule : trig_ctl_asserts

bind trig_ctl trig_ctl_asserts chk (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .meas_start(meas_start), .meas_done(meas_done));
`default_nettype wire

// file: tb/trig_source.sv
// Model of the trigger source and the measurement engine.
`timescale 1ns/1ns
`default_nettype none
module trig_source (
    // Clock.
    input wire logic clock,
    // Trigger pin and engine handshake.
    output logic trig_in,
    input wire logic meas_start,
    output logic meas_done,
    output logic busy
);
    initial begin
        trig_in = 1'b0;
        meas_done = 1'b0;
        busy = 1'b0;
    end
    // One pin pulse three clock periods long, driven just after a rising edge.
    task pulse();
        @(posedge clock);
        trig_in <= 1'b1;
        repeat (3) @(posedge clock);
        trig_in <= 1'b0;
        repeat (3) @(posedge clock);
    endtask : pulse
    // The engine answers each request after a random one to six cycles.
    always @(posedge clock) begin
        if (meas_start === 1'b1) begin
            busy <= 1'b1;
            repeat ($urandom_range(6, 1)) @(posedge clock);
            meas_done <= 1'b1;
            @(posedge clock);
            meas_done <= 1'b0;
            busy <= 1'b0;
        end
    end
endmodule : trig_source
`default_nettype wire

// file: tb/trig_ctl_tb.sv
// Self-checking testbench of the trigger controller.
`timescale 1ns/1ns
`default_nettype none
module trig_ctl_tb;
    logic clock, srst, hsel, hwrite, hreadyout, hresp, trig_in, meas_start, meas_done, eng_busy;
    logic [31:0] haddr, hwdata, hrdata, rd_val;
    logic [1:0] htrans;
    int num_errors = 0;
    int samples_checked = 0;
    int n_meas = 0;
    int base = 0;
    logic [31:0] rq[$];
    int mq[$];
    event rd_ev, m_ev;
    trig_ctl dut (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .trig_in(trig_in), .meas_start(meas_start), .meas_done(meas_done));
    trig_source src (.clock(clock), .trig_in(trig_in), .meas_start(meas_start), .meas_done(meas_done),
        .busy(eng_busy));
    // Free-running clock.
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // Prints the verdict and ends the run.
    task wrap_up();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up
    // Compares one read word.
    task cmp_rd(input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD hrdata expected %h seen %h", exp, got);
        end
    endtask : cmp_rd
    // Compares the measurement count of one scenario.
    task cmp_meas(input int exp, input int got);
        samples_checked++;
        if (got != exp) begin
            num_errors++;
            $display("BAD measurements expected %0d seen %0d", exp, got);
        end
    endtask : cmp_meas
    // Waits for hready at a rising edge, with a bound.
    task wait_rdy();
        for (int i = 0; i < 50; i++) begin
            @(posedge clock);
            if (hreadyout === 1'b1) return;
        end
        num_errors++;
        wrap_up();
    endtask : wait_rdy
    // One single word transfer: address phase, then data phase.
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        rd_val = hrdata & m;
    endtask : xfer
    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
        rq.push_back(e);
        xfer(1'b0, a, 32'h0, m);
        -> rd_ev;
    endtask : rd
    // Returns once the engine has been quiet for sixteen cycles.
    task settle();
        int q;
        q = 0;
        for (int i = 0; i < 600; i++) begin
            @(posedge clock);
            q = (meas_start === 1'b1 || eng_busy) ? 0 : q + 1;
            if (q == 16) return;
        end
        num_errors++;
        wrap_up();
    endtask : settle
    task chk_meas(input int n);
        mq.push_back(n);
        -> m_ev;
    endtask : chk_meas
    task pulses(input int p);
        repeat (p) begin
            src.pulse();
            settle();
        end
    endtask : pulses
    // Stop, configure, issue a command, send pulses and count measurements.
    task run(input logic [6:0] c, input int len, input logic [3:0] cmd, input int p, input int e);
        wr(trig_ctl_pkg::cmd_offset, 32'h8);
        wr(trig_ctl_pkg::ctrl_offset, {25'h0, c});
        wr(trig_ctl_pkg::len_offset, len);
        wr(trig_ctl_pkg::cmd_offset, {28'h0, cmd});
        settle();
        pulses(p);
        chk_meas(e);
    endtask : run
    // Result monitors take the oldest note and compare.
    always @(posedge clock) if (meas_start === 1'b1) n_meas++;
    always @(rd_ev) cmp_rd(rq.pop_front(), rd_val);
    always @(m_ev) begin
        cmp_meas(mq.pop_front(), n_meas - base);
        base = n_meas;
    end
    initial begin
        repeat (60000) @(posedge clock);
        num_errors++;
        wrap_up();
    end
    // Main sequence.
    initial begin
        int len;
        srst = 1'b1;
        hsel = 1'b0;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        void'($urandom(28));
        repeat (12) @(posedge clock);
        srst <= 1'b0;
        rd(trig_ctl_pkg::ctrl_offset, {25'h0000000, trig_ctl_pkg::ctrl_reset});
        rd(trig_ctl_pkg::len_offset, {16'h0000, trig_ctl_pkg::len_reset});
        rd(trig_ctl_pkg::cmd_offset, 32'h0);
        rd(8'h40, 32'h0);
        rd(trig_ctl_pkg::status_offset, 32'h10, 32'h10);
        run(7'h00, 1, 4'h1, 2, 1);
        run(7'h05, 1, 4'h1, 3, 3);
        run(7'h01, 1, 4'h1, 2, 1);
        rd(trig_ctl_pkg::status_offset, 32'h0, 32'h10);
        wr(trig_ctl_pkg::cmd_offset, 32'h2);
        rd(trig_ctl_pkg::status_offset, 32'h10, 32'h10);
        pulses(2);
        chk_meas(1);
        run(7'h41, 1, 4'h2, 2, 1);
        for (int f = 1; f < 4; f++) begin
            len = $urandom_range(4, 1);
            run(7'(f << 4), len, 4'h4, 1, len);
            run(7'(f << 4) | 7'h06, len, 4'h4, 2, len);
            if (f > 1) begin
                run(7'(f << 4) | 7'h01, 2, 4'h4, 3, 2);
                run(7'(f << 4) | 7'h02, len, 4'h4, 2, len);
            end
        end
        // Continuous start in discard response runs self-paced measurements.
        wr(trig_ctl_pkg::ctrl_offset, 32'h40);
        rd(trig_ctl_pkg::ctrl_offset, 32'h40);
        rd(trig_ctl_pkg::status_offset, {29'h00000000, trig_ctl_pkg::st_auto}, 32'h7);
        wr(trig_ctl_pkg::ctrl_offset, 32'h0);
        wrap_up();
    end
endmodule : trig_ctl_tb
`default_nettype wire
